// ---- rtl/sar_conversion_sequencer.sv ----
`timescale 1ns/100ps
module sar_conversion_sequencer (
  input  wire logic                         sys_clk,
  input  wire logic                         sys_rst,
  input  wire logic [3:0]                   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic [7:0]                   trigger_inputs,
  input  wire logic [9:0]                   sar_result,
  output sar_sequencer_pkg::selection_type  active_selection,
  output logic                              sample_hold,
  output logic                              converting,
  output logic                              analog_enable,
  output logic                              conversion_irq
);
  import sar_sequencer_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic          converter_enable;
  logic          conversion_start_bit;
  logic          auto_trigger_enable;
  logic          conversion_done_flag;
  logic          irq_enable;
  logic [2:0]    clock_divider_select;
  logic [2:0]    trigger_source_select;
  logic          converter_power_reduction;
  selection_type shadow_selection;
  logic [9:0]    result;
  logic          result_locked;
  logic          first_pending;
  logic          bank;

  seq_state_type state;
  logic [5:0]    half_count;
  logic [5:0]    len_half;
  logic [5:0]    sh_half;
  logic [1:0]    sync_count;
  logic          trigger_prev;
  logic          completion_seen;
  logic          half_tick;
  logic          phase_high;
  logic          prescale_clear;
  logic          ack;
  logic          wr;
  logic          rd;
  logic          start_write;
  logic          trigger_level;
  logic          trigger_edge;
  logic          finish;
  logic          last_cycle;
  logic          first_conv;
  logic          auto_conv;

  // ----------------------------------------------------------------
  // Decode and trigger selection
  // ----------------------------------------------------------------
  assign ack             = (avs_read || avs_write) && avs_waitrequest;
  assign wr              = avs_write && !avs_waitrequest;
  assign rd              = avs_read && !avs_waitrequest;
  assign start_write     = wr && !bank && avs_address == addr_control_a
                           && avs_writedata[bit_start] && converter_enable
                           && !converter_power_reduction;                     // [R1] [R9]
  assign trigger_level   = (trigger_source_select == source_free_run)
                           ? conversion_done_flag
                           : trigger_inputs[trigger_source_select];          // [R3]
  assign trigger_edge    = auto_trigger_enable && converter_enable
                           && !converter_power_reduction
                           && ((trigger_source_select == source_free_run)
                               ? completion_seen
                               : (trigger_level && !trigger_prev));           // [R4]
  assign finish          = state == seq_conv && half_tick && half_count == len_half - 6'h01;
  // Final converter cycle spans the last two half ticks
  assign last_cycle      = state == seq_conv && half_count + 6'h02 >= len_half;
  // Trigger clears the prescaler so the sample lands at a fixed delay
  assign prescale_clear  = !converter_enable || (state == seq_idle && trigger_edge); // [R10] [R4]
  assign converting      = state != seq_idle;
  assign conversion_irq  = conversion_done_flag && irq_enable;
  assign analog_enable   = converter_enable && !converter_power_reduction;

  // ----------------------------------------------------------------
  // Avalon slave: one wait state per access
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !ack;
    end
  end

  // Second bank at the same offsets holds high result and power bit
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bank <= 1'b0;
    end else if (wr && avs_address == addr_control_b) begin
      bank <= avs_writedata[8];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (ack && avs_read) begin
      avs_readdata <= 32'h0000_0000;
      case ({bank, avs_address})
        {1'b0, addr_control_a}:
          avs_readdata[7:0] <= {converter_enable, conversion_start_bit, auto_trigger_enable,
                                conversion_done_flag, irq_enable, clock_divider_select};
        {1'b0, addr_control_b}:    avs_readdata[8:0] <= {bank, 5'h00, trigger_source_select};
        {1'b0, addr_input_select}: avs_readdata[7:0] <= {shadow_selection[5:4], 2'h0,
                                                          shadow_selection[3:0]};
        {1'b0, addr_result_low}:   avs_readdata[7:0] <= result[7:0];
        {1'b1, addr_result_high}:  avs_readdata[1:0] <= result[9:8];
        {1'b1, addr_power}:        avs_readdata[8:0] <= {bank, 7'h00, converter_power_reduction};
        default:                   avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      converter_enable     <= 1'b0;
      auto_trigger_enable  <= 1'b0;
      irq_enable           <= 1'b0;
      clock_divider_select <= 3'h0;
    end else if (wr && !bank && avs_address == addr_control_a) begin
      converter_enable     <= avs_writedata[bit_enable];
      auto_trigger_enable  <= avs_writedata[bit_auto];                         // [R3]
      irq_enable           <= avs_writedata[bit_irq_enable];
      clock_divider_select <= avs_writedata[div_msb:0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigger_source_select <= 3'h0;
    end else if (wr && !bank && avs_address == addr_control_b) begin
      trigger_source_select <= avs_writedata[2:0];                              // [R3]
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      converter_power_reduction <= 1'b1;
    end else if (wr && bank && avs_address == addr_power) begin
      converter_power_reduction <= avs_writedata[0];
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      shadow_selection <= '0;
    end else if (wr && !bank && avs_address == addr_input_select) begin
      shadow_selection <= {avs_writedata[7:6], avs_writedata[3:0]};
    end
  end

  // Set wins over software's write-one-to-clear
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_done_flag <= 1'b0;
    end else if (finish) begin
      conversion_done_flag <= 1'b1;                                             // [R6] [R14]
    end else if (wr && !bank && avs_address == addr_control_a && avs_writedata[bit_done]) begin
      conversion_done_flag <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Start bit: set by write, stays set while busy
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      conversion_start_bit <= 1'b0;
    end else if (!converter_enable) begin
      conversion_start_bit <= 1'b0;
    end else if (start_write || (state == seq_idle && trigger_edge)) begin
      conversion_start_bit <= 1'b1;                                             // [R9]
    end else if (finish && !(auto_trigger_enable
                             && trigger_source_select == source_free_run)) begin
      conversion_start_bit <= 1'b0;                                             // [R14] [R16]
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      trigger_prev <= 1'b0;
    end else begin
      trigger_prev <= trigger_level;                                            // [R5]
    end
  end

  // Free running restarts on every completion, flag cleared or not
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      completion_seen <= 1'b0;
    end else begin
      completion_seen <= finish;                                                // [R7] [R16]
    end
  end

  // First conversion after enable is the long one
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      first_pending <= 1'b1;
    end else if (!converter_enable) begin
      first_pending <= 1'b1;
    end else if (finish) begin
      first_pending <= 1'b0;
    end
  end

  assign first_conv = first_pending;

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      phase_high <= 1'b0;
    end else if (prescale_clear) begin
      phase_high <= 1'b0;
    end else if (half_tick) begin
      phase_high <= !phase_high;
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      state      <= seq_idle;
      half_count <= 6'h00;
      sync_count <= 2'h0;
      auto_conv  <= 1'b0;
    end else if (!converter_enable) begin
      state <= seq_idle;
    end else begin
      case (state)
        seq_idle: begin
          if (trigger_edge) begin
            state      <= seq_sync;                                            // [R4] [R7]
            sync_count <= 2'h1;
            auto_conv  <= 1'b1;
          end else if (start_write) begin
            state     <= seq_wait;                                             // [R1]
            auto_conv <= 1'b0;
          end
        end
        seq_sync: begin
          // Three core cycles of trigger synchronisation
          sync_count <= sync_count + 2'h1;
          if (sync_count == trigger_sync_len) begin
            state      <= seq_conv;                                            // [R15]
            half_count <= 6'h00;
          end
        end
        seq_wait: begin
          if (half_tick && !phase_high) begin
            state      <= seq_conv;                                            // [R11]
            half_count <= 6'h00;
          end
        end
        seq_conv: begin
          if (finish) begin
            state <= seq_idle;                                                 // [R5]
          end else if (half_tick) begin
            half_count <= half_count + 6'h01;
          end
        end
        default: state <= seq_idle;
      endcase
    end
  end

  always_comb begin
    len_half = half_normal_len;                                                // [R12]
    sh_half  = half_normal_sh;                                                 // [R13]
    if (first_conv) begin
      len_half = half_first_len;
      sh_half  = half_first_sh;
    end else if (auto_conv) begin
      len_half = half_auto_len;
      sh_half  = half_auto_sh;                                                 // [R15]
    end
  end

  // ----------------------------------------------------------------
  // Sample and hold, counted in half converter clocks
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_hold <= 1'b0;
    end else begin
      sample_hold <= state == seq_conv && half_tick && half_count == sh_half - 6'h01; // [R13]
    end
  end

  // Selection follows shadow while enabled, except in seq_conv before its last cycle
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      active_selection <= '0;
    end else if (converter_enable && (state != seq_conv || last_cycle)) begin
      active_selection <= shadow_selection;                         // [R2] [R17] [R18] [R21] [R23]
    end
  end

  // ----------------------------------------------------------------
  // Result with read lock
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result_locked <= 1'b0;
    end else if (rd && bank && avs_address == addr_result_high) begin
      result_locked <= 1'b0;                                                   // [R24]
    end else if (rd && !bank && avs_address == addr_result_low) begin
      result_locked <= 1'b1;                                                   // [R24]
    end
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      result <= 10'h000;
    end else if (finish && !result_locked) begin
      result <= sar_result;                                                    // [R14] [R24]
    end
  end

  clock_prescaler prescaler (
    .sys_clk              (sys_clk),
    .sys_rst              (sys_rst),
    .clear                (prescale_clear),
    .clock_divider_select (clock_divider_select),
    .half_tick            (half_tick)
  );

endmodule

// ---- rtl/sar_sequencer_pkg.sv ----
// Contract
// R1 - Start bit write starts single conversion
// R2 - Channel change waits for running conversion
// R3 - Auto-trigger enable bit, source from control B
// R4 - Trigger rising edge resets prescaler, starts
// R5 - Ignore edges during conversion, no level restart
// R6 - Done flag set regardless of interrupt enables
// R7 - Done-flag trigger restarts after every conversion
// R8 - Software starts first free-running conversion
// R9 - Start bit works under auto; reads busy
// R10 - Prescaler runs when enabled, reset otherwise
// R11 - Start-bit conversion begins next converter edge
// R12 - Conversion 13 cycles, first one 25
// R13 - Sample at 1.5 or 13.5 cycles
// R14 - Completion writes result, sets flag, clears start
// R15 - Auto conversion: sample at 2, sync three clocks
// R16 - Free running restarts immediately, start stays set
// R17 - Selection shadowed, frozen during conversion
// R18 - Selection copying resumes in last cycle
// R19 - Software waits a converter clock before reselect
// R20 - Software reselects only at safe points
// R21 - Free-running change affects result after next
// R22 - Software discards first result after reference switch
// R23 - Selections apply only while converter enabled
// R24 - Low-byte read locks results until high read
// R25 - Divider select picks power-of-two ratio
package sar_sequencer_pkg;

  // ----------------------------------------------------------------
  // Register map (word offsets are byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] addr_control_a    = 4'h0;
  localparam logic [3:0] addr_control_b    = 4'h4;
  localparam logic [3:0] addr_input_select = 4'h8;
  localparam logic [3:0] addr_result_low   = 4'hc;
  localparam logic [3:0] addr_result_high  = 4'h0;
  localparam logic [3:0] addr_power        = 4'h4;

  // Control A bits
  localparam int bit_enable      = 7;
  localparam int bit_start       = 6;
  localparam int bit_auto        = 5;
  localparam int bit_done        = 4;
  localparam int bit_irq_enable  = 3;
  localparam int div_msb         = 2;

  // ----------------------------------------------------------------
  // Timing, in half converter clocks, except trigger_sync_len in core clocks
  // ----------------------------------------------------------------
  localparam logic [5:0] half_normal_len   = 6'h1a;  // 13 cycles
  localparam logic [5:0] half_first_len    = 6'h32;  // 25 cycles
  localparam logic [5:0] half_auto_len     = 6'h1b;  // 13.5 cycles
  localparam logic [5:0] half_normal_sh    = 6'h03;  // 1.5 cycles
  localparam logic [5:0] half_first_sh     = 6'h1b;  // 13.5 cycles
  localparam logic [5:0] half_auto_sh      = 6'h04;  // 2 cycles
  localparam logic [1:0] trigger_sync_len  = 2'h3;   // core clocks

  localparam logic [2:0] source_free_run   = 3'h0;

  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_sync = 2'b01,
    seq_wait = 2'b10,
    seq_conv = 2'b11
  } seq_state_type;

  typedef struct packed {
    logic [1:0] reference_select;
    logic [3:0] channel_select;
  } selection_type;

endpackage

// ---- rtl/clock_prescaler.sv ----
`timescale 1ns/100ps
module clock_prescaler (
  input  wire logic       sys_clk,
  input  wire logic       sys_rst,
  input  wire logic       clear,
  input  wire logic [2:0] clock_divider_select,
  output logic            half_tick
);
  import sar_sequencer_pkg::*;

  logic [7:0] count;
  logic [7:0] half_mask;

  // Power-of-two ratio, half period emits a tick
  always_comb begin
    half_mask = 8'h00;
    case (clock_divider_select)
      3'h0, 3'h1: half_mask = 8'h00;                              // [R25]
      default:    half_mask = 8'hff >> (4'h9 - {1'b0, clock_divider_select});
    endcase
  end

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      count <= 8'h00;
    end else if (clear) begin
      count <= 8'h00;                                                // [R10]
    end else if ((count & half_mask) == half_mask) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h01;
    end
  end

  assign half_tick = !clear && ((count & half_mask) == half_mask);

endmodule

// ---- testbench/sar_sequencer_props.sv ----
`timescale 1ns/100ps
module sar_sequencer_props (
  input wire logic                             sys_clk,
  input wire logic                             sys_rst,
  input wire logic                             avs_read,
  input wire logic                             avs_write,
  input wire logic [31:0]                      avs_readdata,
  input wire logic                             avs_waitrequest,
  input wire sar_sequencer_pkg::selection_type active_selection,
  input wire logic                             sample_hold,
  input wire logic                             converting,
  input wire logic                             analog_enable
);
  import sar_sequencer_pkg::*;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);
  // ----------------------------------------------------------------
  // Steps of a conversion after its sample
  // ----------------------------------------------------------------
  sequence conv_hold;
    converting [*3];
  endsequence
  sequence sel_hold;
    $stable(active_selection) [*8];
  endsequence
  ack_next_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("request not answered next cycle");
  one_low_a: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low longer than one cycle");
  idle_high_a: assert property (!(avs_read || avs_write) |=> avs_waitrequest)
    else $error("waitrequest low without request");
  rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data changed without read");
  sh_pulse_a: assert property (sample_hold |=> !sample_hold)
    else $error("sample pulse too long");
  sh_conv_a: assert property (sample_hold |-> conv_hold)
    else $error("sample outside conversion");
  sel_frozen_a: assert property (sample_hold |-> sel_hold)
    else $error("selection moved during conversion");
  off_idle_a: assert property (!analog_enable [*2] |-> !converting)
    else $error("conversion while disabled");
  off_sel_a: assert property (!analog_enable && !$past(analog_enable) |-> $stable(active_selection))
    else $error("selection applied while disabled");
endmodule

bind sar_conversion_sequencer sar_sequencer_props u_props (
  .sys_clk          (sys_clk),
  .sys_rst          (sys_rst),
  .avs_read         (avs_read),
  .avs_write        (avs_write),
  .avs_readdata     (avs_readdata),
  .avs_waitrequest  (avs_waitrequest),
  .active_selection (active_selection),
  .sample_hold      (sample_hold),
  .converting       (converting),
  .analog_enable    (analog_enable)
);

// ---- testbench/sar_analog_model.sv ----
`timescale 1ns/100ps
module sar_analog_model (
  input  wire logic                             sys_clk,
  input  wire logic                             sys_rst,
  input  wire logic                             sample_hold,
  input  wire sar_sequencer_pkg::selection_type active_selection,
  output logic [9:0]                            sar_result
);
  import sar_sequencer_pkg::*;
  logic [3:0] sample_count;
  // ----------------------------------------------------------------
  // Held value: sample index above the selection sampled
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sample_count <= 4'h0;
      sar_result   <= 10'h000;
    end else if (sample_hold) begin
      sample_count <= sample_count + 4'h1;
      sar_result   <= {sample_count, active_selection};
    end
  end
endmodule

// ---- testbench/sar_conversion_sequencer_tb_top.sv ----
`timescale 1ns/100ps
module sar_conversion_sequencer_tb_top;
  import sar_sequencer_pkg::*;
  logic          sys_clk, sys_rst, avs_read, avs_write, avs_waitrequest;
  logic          sample_hold, converting, analog_enable, conversion_irq;
  logic [3:0]    avs_address;
  logic [7:0]    trigger_inputs;
  logic [9:0]    sar_result;
  logic [31:0]   avs_writedata, avs_readdata, rd;
  selection_type active_selection;
  selection_type sh_sel [16];
  int            n_mismatch, samples_checked, sh_n, n_done, cnt, shi, len, tail, t, m;

  sar_conversion_sequencer u_dut (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .avs_address      (avs_address),
    .avs_read         (avs_read),
    .avs_write        (avs_write),
    .avs_writedata    (avs_writedata),
    .avs_readdata     (avs_readdata),
    .avs_waitrequest  (avs_waitrequest),
    .trigger_inputs   (trigger_inputs),
    .sar_result       (sar_result),
    .active_selection (active_selection),
    .sample_hold      (sample_hold),
    .converting       (converting),
    .analog_enable    (analog_enable),
    .conversion_irq   (conversion_irq)
  );
  sar_analog_model u_model (
    .sys_clk          (sys_clk),
    .sys_rst          (sys_rst),
    .sample_hold      (sample_hold),
    .active_selection (active_selection),
    .sar_result       (sar_result)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // Monitor: conversion length and sample-to-end span
  // ----------------------------------------------------------------
  always @(posedge sys_clk) begin
    if (converting === 1'b1)
      cnt <= cnt + 1;
    if (sample_hold === 1'b1) begin
      shi              <= cnt;
      sh_sel[sh_n % 16] <= active_selection;
      sh_n             <= sh_n + 1;
    end
    if (converting === 1'b0 && cnt != 0) begin
      len    <= cnt;
      tail   <= cnt - shi;
      cnt    <= 0;
      n_done <= n_done + 1;
    end
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wait_ack;
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge sys_clk);
      if (avs_waitrequest === 1'b0)
        return;
    end
    check("waitrequest", 32'h1, 32'h0);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= 1'b1;
    wait_ack();
    avs_write <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a);
    @(posedge sys_clk);
    avs_address <= a;
    avs_read    <= 1'b1;
    wait_ack();
    rd = avs_readdata;
    avs_read <= 1'b0;
  endtask
  task automatic rdc(input logic [3:0] a, input logic [31:0] exp, input string what);
    rd_reg(a);
    check(what, rd, exp);
  endtask
  task automatic wait_for(input int k, input bit on_sample);
    int i;
    for (i = 0; i < 600; i++) begin
      @(posedge sys_clk);
      if ((on_sample ? sh_n : n_done) >= k)
        return;
    end
    check("event count", 32'h0, 32'h1);
  endtask
  task automatic read_high(input logic [31:0] exp);
    wr(4'h4, 32'h100);
    rdc(4'h0, exp, "result high");
    wr(4'h4, 32'h0);
  endtask

  task automatic t_reset;
    rdc(4'h0, 32'h0, "ctrl a");
    rdc(4'h8, 32'h0, "select");
    wr(4'h0, 32'hc0);
    rdc(4'h0, 32'h80, "start gated");
    check("busy gated", 32'(converting), 32'h0);
    wr(4'h4, 32'h100);
    rdc(4'h4, 32'h101, "power");
    rdc(4'h8, 32'h0, "unmapped");
    wr(4'h4, 32'h0);
  endtask
  task automatic t_single;
    wr(4'h8, 32'h43);
    m = n_done;
    wr(4'h0, 32'hc0);
    rdc(4'h0, 32'hc0, "start busy");
    wr(4'h8, 32'h85);
    check("frozen sel", 32'(active_selection), 32'h13);
    wait_for(m + 1, 1'b0);
    check("first len", 32'(len >= 50 && len <= 54), 32'h1);
    check("first tail", 32'(tail >= 22 && tail <= 24), 32'h1);
    rdc(4'h0, 32'h90, "done");
    check("irq off", 32'(conversion_irq), 32'h0);
    rdc(4'hc, 32'h13, "result low");
    read_high(32'h0);
    check("new sel", 32'(active_selection), 32'h25);
    wr(4'h0, 32'hc0);
    wait_for(m + 2, 1'b0);
    check("normal len", 32'(len >= 26 && len <= 30), 32'h1);
    check("normal tail", 32'(tail >= 22 && tail <= 24), 32'h1);
  endtask
  task automatic t_lock;
    rdc(4'hc, 32'h65, "result low");
    wr(4'h0, 32'h98);
    rdc(4'h0, 32'h88, "done cleared");
    wr(4'h0, 32'hc8);
    wait_for(m + 3, 1'b0);
    check("irq", 32'(conversion_irq), 32'h1);
    rdc(4'hc, 32'h65, "locked low");
    read_high(32'h0);
    wr(4'h0, 32'hda);
    wait_for(m + 4, 1'b0);
    check("div len", 32'(len >= 52 && len <= 58), 32'h1);
    rdc(4'hc, 32'he5, "unlocked low");
    read_high(32'h0);
  endtask
  task automatic t_auto;
    wr(4'h4, 32'h1);
    wr(4'h0, 32'hb0);
    m = n_done;
    trigger_inputs <= 8'h02;
    for (t = 0; t < 40 && sample_hold !== 1'b1; t++)
      @(posedge sys_clk);
    check("trigger delay", 32'(t >= 5 && t <= 10), 32'h1);
    rdc(4'h0, 32'he0, "start auto");
    trigger_inputs <= 8'h00;
    @(posedge sys_clk);
    trigger_inputs <= 8'h02;
    wait_for(m + 1, 1'b0);
    check("auto tail", 32'(tail >= 22 && tail <= 24), 32'h1);
    repeat (60) @(posedge sys_clk);
    check("no restart", 32'(n_done), 32'(m + 1));
    trigger_inputs <= 8'h00;
    wr(4'h0, 32'he0);
    wait_for(m + 2, 1'b0);
  endtask
  task automatic t_free;
    int i;
    wr(4'h4, 32'h0);
    wr(4'h8, 32'h43);
    m = sh_n;
    wr(4'h0, 32'hf0);
    rd = 32'h0;
    for (i = 0; i < 40 && rd[4] !== 1'b1; i++)
      rd_reg(4'h0);
    wr(4'h8, 32'h85);
    wait_for(m + 3, 1'b1);
    check("next sel", 32'(sh_sel[(m + 1) % 16]), 32'h13);
    check("later sel", 32'(sh_sel[(m + 2) % 16]), 32'h25);
    rdc(4'h0, 32'hf0, "free start");
    wr(4'h0, 32'h0);
    repeat (4) @(posedge sys_clk);
    check("stopped", 32'({analog_enable, converting}), 32'h0);
    wr(4'h8, 32'h01);
    repeat (4) @(posedge sys_clk);
    check("off sel", 32'(active_selection), 32'h25);
  endtask

  task automatic print_verdict;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    sys_rst        = 1'b1;
    avs_address    = 4'h0;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0;
    trigger_inputs = 8'h00;
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_single();
    t_lock();
    t_auto();
    t_free();
    print_verdict();
  end
endmodule
